// file: hdl/pbss_regs.svh
// constants for the pipelined burst sram model
`ifndef PBSS_REGS_SVH
`define PBSS_REGS_SVH
`define PBSS_ADDR_W 18
`define PBSS_DATA_W 18
`define PBSS_LANE_W 9
`define PBSS_LANES 2
`define PBSS_DEPTH 262144
`define PBSS_LO_W 2
`define PBSS_CNT_RST 2'h0
`define PBSS_CNT_ONE 2'h1
`define PBSS_LANES_ALL 2'h3
`define PBSS_LANES_NONE 2'h0
`define PBSS_MODE_RST 1'h1
`define PBSS_ZZS_TCYC 2
`define PBSS_ZZREC_TCYC 2
`define PBSS_ZZ_CNT_W 2
`define PBSS_ZZ_STEP 2'h1
`endif

// file: hdl/pbss_pkg.sv
// types for the pipelined burst sram model
`include "pbss_regs.svh"
package pbss_pkg;
	typedef struct packed {
		logic processor_addr_strobe_n_n;
		logic controller_addr_strobe_n_n;
		logic adv_n;
		logic gw_n;
		logic bwe_n;
		logic [`PBSS_LANES-1:0] bw_n;
		logic ce1_n;
		logic ce2;
		logic ce3_n;
		logic [`PBSS_ADDR_W-1:0] addr;
		logic [`PBSS_DATA_W-1:0] din;
	} pbss_bus_type;
	typedef enum logic [1:0] {
		AWAKE,
		ENTERING,
		ASLEEP,
		EXITING
	} pbss_sleep_type;
endpackage

// file: hdl/pbss_sram.sv
// pipelined synchronous burst sram, common data io
`timescale 1ns/10ps
`default_nettype none
`include "pbss_regs.svh"
// Overview of operation
// - synchronous inputs registered on rising edge; read data leaves via register.
// - strap low gives linear order, high gives interleaved; default interleaved.
// - two-bit wrapping counter clears at start, offsets start low bits for later addresses.
// - advance low at a rise steps the counter, reads and writes alike.
// - processor strobe is ignored while first chip select is high.
// - strobe, all selects active, no writes: read starts, address latched.
// - read data reaches output register, driven after next rise if enabled.
// - first cycle after leaving deselect keeps outputs off, whatever enable.
// - deselect by selects and a strobe turns outputs off at once.
// - processor strobe cycle latches address, ignores writes and advance.
// - processor strobe write takes two cycles; second rise commits it.
// - global write writes all bytes; otherwise byte enable and selects decide.
// - only selected lanes are written; others keep their contents.
// - outputs forced off whenever a write cycle is seen.
// - controller strobe write with valid controls completes in one cycle.
// - controller strobe cycle ignores advance and loads the external address.
// - sleep keeps contents; entry and exit each take two cycles.
// - access in flight at sleep entry may be dropped as invalid.
// - interleaved order is start xor count.
// - linear order counts up from start, wrapping modulo four.
// - processor strobe cycle always begins as a read.
// - output enable is unclocked and masked through a write cycle.
module pbss_sram (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pbss_pkg::pbss_bus_type bus_i,
	input wire logic output_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic burst_order_i,
	output logic [`PBSS_DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic sleep_active_o
);
	pbss_pkg::pbss_bus_type in_q;
	pbss_pkg::pbss_sleep_type zz_st_q;
	logic [`PBSS_DATA_W-1:0] mem [0:`PBSS_DEPTH-1];
	logic [`PBSS_ADDR_W-1:0] base_q;
	logic [`PBSS_LO_W-1:0] cnt_q;
	logic [`PBSS_ZZ_CNT_W-1:0] zz_cnt_q;
	logic sel_q;
	logic oe1_q, oe_s_q, zz1_q, zz_s_q, md1_q, mode_q;
	logic awake, cs_ok, p_act, c_act, wr_any, start, desel, cont;
	logic wr_now, rd_now;
	logic [`PBSS_LO_W-1:0] cnt_use, lo_use;
	logic [`PBSS_ADDR_W-1:0] addr_now;
	logic [`PBSS_LANES-1:0] lane_we;

	// pins from the master share our clock: one register stage
	always_ff @(posedge clk_i) begin
		in_q <= bus_i;
	end

	// unclocked pins and the strap come through two flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe1_q <= 1'h1;
			oe_s_q <= 1'h1;
			zz1_q <= 1'h0;
			zz_s_q <= 1'h0;
			md1_q <= `PBSS_MODE_RST;
			mode_q <= `PBSS_MODE_RST;
		end else begin
			oe1_q <= output_enable_n_i;
			oe_s_q <= oe1_q;
			zz1_q <= sleep_request_i;
			zz_s_q <= zz1_q;
			md1_q <= burst_order_i;
			mode_q <= md1_q;
		end
	end

	// cycle decode on the captured pins
	always_comb begin
		awake = (zz_st_q == pbss_pkg::AWAKE);
		cs_ok = !in_q.ce1_n && in_q.ce2 && !in_q.ce3_n;
		p_act = !in_q.processor_addr_strobe_n_n && !in_q.ce1_n;
		c_act = !in_q.controller_addr_strobe_n_n && !p_act;
		wr_any = !in_q.gw_n || (!in_q.bwe_n && (in_q.bw_n != `PBSS_LANES_ALL));
		start = awake && (p_act || c_act) && cs_ok;
		desel = awake && (p_act || c_act) && !cs_ok;
		cont = awake && !p_act && !c_act && sel_q;
		// a processor strobe cycle is always a read
		wr_now = (c_act && start && wr_any) || (cont && wr_any);
		rd_now = (start && !wr_now) || (cont && !wr_any);
	end

	// byte lanes: global write wins, else enable plus selects
	always_comb begin
		if (!in_q.gw_n) begin
			lane_we = `PBSS_LANES_ALL;
		end else if (!in_q.bwe_n) begin
			lane_we = ~in_q.bw_n;
		end else begin
			lane_we = `PBSS_LANES_NONE;
		end
	end

	// address in use: external on a strobe, counter otherwise
	always_comb begin
		cnt_use = cnt_q;
		if (cont && !in_q.adv_n) begin
			cnt_use = cnt_q + `PBSS_CNT_ONE;
		end
		if (mode_q) begin
			lo_use = base_q[`PBSS_LO_W-1:0] ^ cnt_use;
		end else begin
			lo_use = base_q[`PBSS_LO_W-1:0] + cnt_use;
		end
		addr_now = {base_q[`PBSS_ADDR_W-1:`PBSS_LO_W], lo_use};
		if (start) begin
			addr_now = in_q.addr;
		end
	end

	// address register and burst counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_q <= '0;
			cnt_q <= `PBSS_CNT_RST;
		end else if (start) begin
			// advance is ignored on a strobe cycle
			base_q <= in_q.addr;
			cnt_q <= `PBSS_CNT_RST;
		end else if (cont) begin
			cnt_q <= cnt_use;
		end
	end

	// selected state; sleep drops any open burst
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q <= 1'h0;
		end else if (!awake) begin
			sel_q <= 1'h0;
		end else if (start) begin
			sel_q <= 1'h1;
		end else if (desel) begin
			sel_q <= 1'h0;
		end
	end

	// array writes, one lane per loop pass; contents survive sleep
	// a single process owns the whole array so the lanes never fight as drivers
	always_ff @(posedge clk_i) begin
		for (int l = 0; l < `PBSS_LANES; l++) begin
			if (wr_now && lane_we[l]) begin
				mem[addr_now][l*`PBSS_LANE_W +: `PBSS_LANE_W] <=
					in_q.din[l*`PBSS_LANE_W +: `PBSS_LANE_W];
			end
		end
	end

	// output register and drive enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dq_o <= '0;
			dq_oe_o <= 1'h0;
		end else begin
			if (rd_now) begin
				dq_o <= mem[addr_now];
			end
			// write, deselect, sleep and emerging cycles never drive
			dq_oe_o <= rd_now && !oe_s_q && !(start && !sel_q);
		end
	end

	// sleep sequencing: two cycles to enter, two to leave
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zz_st_q <= pbss_pkg::AWAKE;
			zz_cnt_q <= '0;
		end else begin
			case (zz_st_q)
				pbss_pkg::AWAKE: begin
					if (zz_s_q) begin
						zz_st_q <= pbss_pkg::ENTERING;
						zz_cnt_q <= `PBSS_ZZ_CNT_W'(`PBSS_ZZS_TCYC - 1);
					end
				end
				pbss_pkg::ENTERING: begin
					if (zz_cnt_q == '0) begin
						zz_st_q <= pbss_pkg::ASLEEP;
					end else begin
						zz_cnt_q <= zz_cnt_q - `PBSS_ZZ_STEP;
					end
				end
				pbss_pkg::ASLEEP: begin
					if (!zz_s_q) begin
						zz_st_q <= pbss_pkg::EXITING;
						zz_cnt_q <= `PBSS_ZZ_CNT_W'(`PBSS_ZZREC_TCYC - 1);
					end
				end
				pbss_pkg::EXITING: begin
					if (zz_cnt_q == '0) begin
						zz_st_q <= pbss_pkg::AWAKE;
					end else begin
						zz_cnt_q <= zz_cnt_q - `PBSS_ZZ_STEP;
					end
				end
				default: begin
					zz_st_q <= pbss_pkg::AWAKE;
				end
			endcase
		end
	end

	// status pin follows the sleep state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_active_o <= 1'h0;
		end else begin
			sleep_active_o <= (zz_st_q == pbss_pkg::ASLEEP);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_zz_rise;
		awake && zz_s_q;
	endsequence
	// status pin lags the state register by one edge, hence four ticks
	sequence s_zz_in;
		##4 sleep_active_o;
	endsequence
	sequence s_zz_fall;
		zz_st_q == pbss_pkg::ASLEEP && !zz_s_q;
	endsequence
	sequence s_zz_out;
		##3 awake;
	endsequence

	p_ignored_a: assert property (
		awake && in_q.ce1_n && in_q.controller_addr_strobe_n_n |=> $stable(base_q))
		else $error("processor strobe acted with select high");
	rd_latch_a: assert property (
		start |=> base_q == $past(in_q.addr) && cnt_q == `PBSS_CNT_RST)
		else $error("start did not latch address");
	first_tri_a: assert property (
		start && !sel_q |=> !dq_oe_o)
		else $error("drove data in first emerging cycle");
	desel_tri_a: assert property (
		desel |=> !dq_oe_o && !sel_q)
		else $error("outputs on after deselect");
	wr_tri_a: assert property (
		wr_now |=> !dq_oe_o)
		else $error("outputs on during write");
	p_read_a: assert property (
		p_act && start |-> !wr_now && rd_now)
		else $error("processor strobe cycle wrote");
	step_a: assert property (
		cont && !in_q.adv_n |=> cnt_q == $past(cnt_q) + `PBSS_CNT_ONE)
		else $error("advance did not step counter");
	hold_a: assert property (
		cont && in_q.adv_n ##1 cont && in_q.adv_n |-> $stable(cnt_q))
		else $error("counter moved without advance");
	lane_keep_a: assert property (
		in_q.gw_n && in_q.bw_n[0] |-> !lane_we[0])
		else $error("unselected lane written");
	both_strb_a: assert property (
		!in_q.processor_addr_strobe_n_n && !in_q.ce1_n |-> !c_act)
		else $error("controller strobe acted with processor strobe");
	zz_enter_a: assert property (
		s_zz_rise |-> s_zz_in)
		else $error("sleep entry not two cycles");
	zz_quiet_a: assert property (
		!awake |=> !dq_oe_o && !sel_q)
		else $error("activity while sleeping");

	// sleep exit and lane decode, then effects on the array and the output register, one edge after the decode
	zz_exit_a: assert property (
		s_zz_fall |-> s_zz_out)
		else $error("sleep exit not two cycles");
	lane_hi_keep_a: assert property (
		in_q.gw_n && in_q.bw_n[1] |-> !lane_we[1])
		else $error("unselected upper lane written");
	gw_all_a: assert property (
		!in_q.gw_n |-> lane_we == `PBSS_LANES_ALL)
		else $error("global write missed a lane");
	lane_none_a: assert property (
		in_q.gw_n && in_q.bwe_n |-> lane_we == `PBSS_LANES_NONE)
		else $error("lane written without byte enable");
	ctl_write_a: assert property (
		c_act && start && !in_q.gw_n |=> mem[$past(in_q.addr)] == $past(in_q.din))
		else $error("controller write not done in one cycle");
	cont_write_a: assert property (
		cont && !in_q.gw_n |=> mem[$past(addr_now)] == $past(in_q.din))
		else $error("second cycle write not committed");
	read_data_a: assert property (
		rd_now |=> dq_o == $past(mem[addr_now]))
		else $error("read data not registered");
	rd_drive_a: assert property (
		rd_now && sel_q && !oe_s_q |=> dq_oe_o)
		else $error("enabled read not driven");
endmodule // pbss_sram
`default_nettype wire

// file: test/pbss_master.sv
// bus master model that drives the sram pins
`timescale 1ns/10ps
`default_nettype none
module pbss_master (
	input wire logic clk_i,
	input wire logic [17:0] dq_i,
	output pbss_pkg::pbss_bus_type bus_o,
	output logic oe_n_o,
	output logic sleep_o
);
	logic [17:0] rdat;
	// idle, deselected and awake at time zero
	initial begin
		bus_o = {7'h7f, 3'h6, 18'h0, 18'h0};
		oe_n_o = 1'h1;
		sleep_o = 1'h0;
	end
	// one pin cycle launched just after the edge; c is strobes, advance, writes
	task cyc(input logic [6:0] c, input logic [2:0] s, input logic [17:0] a, input logic [17:0] d);
		@(posedge clk_i);
		#1;
		bus_o = {c, s, a, d};
	endtask
	// released data lines toggle so a stale value cannot pass for data
	task idle(input int n);
		repeat (n) cyc(7'h7f, 3'h2, bus_o.addr, ~bus_o.din);
	endtask
	// start or step, then let the pipeline settle before sampling
	task look(input logic [6:0] c, input logic [2:0] s, input logic [17:0] a);
		cyc(c, s, a, ~bus_o.din);
		idle(4);
		rdat = dq_i;
	endtask
	// output enable passes two flops, so give it time before traffic
	task oe(input logic v);
		oe_n_o = v;
		idle(3);
	endtask
	// deselect first, keep selects and strobes idle around sleep
	task zz(input logic v);
		cyc(7'h5f, 3'h5, bus_o.addr, ~bus_o.din);
		sleep_o = v;
		repeat (8) cyc(7'h7f, 3'h5, bus_o.addr, ~bus_o.din);
	endtask
endmodule // pbss_master
`default_nettype wire

// file: test/test_pbss_sram.sv
// self-checking bench for the burst sram
`timescale 1ns/10ps
`default_nettype none
module test_pbss_sram;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic strap = 1'h1;
	pbss_pkg::pbss_bus_type bus;
	logic oe_n, zz, oe, slp;
	logic [17:0] dq;
	logic [17:0] e [4] = '{18'h11111, 18'h22222, 18'h0c3c3, 18'h3a5a5};
	int failures = 0;
	int cmp_count = 0;
	// a released data bus reads back inverted, so undriven data cannot pass
	pbss_master m (.clk_i(clk_i), .dq_i(oe ? dq : ~dq), .bus_o(bus), .oe_n_o(oe_n), .sleep_o(zz));
	pbss_sram DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .output_enable_n_i(oe_n),
		.sleep_request_i(zz), .burst_order_i(strap), .dq_o(dq), .dq_oe_o(oe), .sleep_active_o(slp));
	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task check(input string n, input logic [17:0] s, input logic [17:0] x);
		cmp_count++;
		if (s !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// the strap only moves while reset holds the memory idle
	task rst(input logic s);
		@(posedge clk_i);
		#1;
		rst_i = 1'h1;
		strap = s;
		repeat (4) @(posedge clk_i);
		#1;
		rst_i = 1'h0;
	endtask
	// four beats, stepping with advance after the first
	task burst(input logic [1:0] st, input logic lin);
		logic [1:0] k;
		for (int i = 0; i < 4; i++) begin
			k = lin ? st + 2'(i) : st ^ 2'(i);
			m.look(i == 0 ? 7'h3f : 7'h6f, 3'h2, 18'(st));
			check("burst beat", m.rdat, e[k]);
		end
	endtask
	// hang guard, far beyond the roughly 130 cycles of the run
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		#1;
		rst_i = 1'h0;
		m.oe(1'h1);
		for (int i = 0; i < 4; i++) m.cyc(7'h57, 3'h2, 18'(i), e[i]);
		m.cyc(7'h5a, 3'h2, 18'h0, 18'h3ffff);
		e[0][8:0] = 9'h1ff;
		m.cyc(7'h59, 3'h2, 18'h3, 18'h3ffff);
		e[3][17:9] = 9'h1ff;
		m.cyc(7'h37, 3'h2, 18'h2, 18'h0);
		m.cyc(7'h77, 3'h2, 18'h5, 18'h12345);
		e[2] = 18'h12345;
		m.cyc(7'h17, 3'h2, 18'h3, 18'h0);
		m.oe(1'h0);
		for (int i = 0; i < 4; i++) begin
			m.look(7'h3f, 3'h2, 18'(i));
			check("read word", m.rdat, e[i]);
		end
		check("drive on", {17'h0, oe}, 18'h1);
		// write with enable low: drivers must still drop
		m.cyc(7'h57, 3'h2, 18'h1, 18'h2bcde);
		m.idle(1);
		e[1] = 18'h2bcde;
		@(posedge clk_i);
		#2;
		check("drive in write", {17'h0, oe}, 18'h0);
		m.look(7'h3f, 3'h2, 18'h0);
		m.look(7'h3f, 3'h6, 18'h1);
		check("strobe ignored", m.rdat, e[0]);
		m.look(7'h3f, 3'h0, 18'h1);
		check("deselect off", {17'h0, oe}, 18'h0);
		// first beat after deselect stays off, the next one drives
		m.cyc(7'h3f, 3'h2, 18'h1, 18'h0);
		m.idle(1);
		@(posedge clk_i);
		#2;
		check("emerging off", {17'h0, oe}, 18'h0);
		@(posedge clk_i);
		#2;
		check("emerged on", {17'h0, oe}, 18'h1);
		burst(2'h1, 1'h0);
		m.zz(1'h1);
		check("sleep on", {17'h0, slp}, 18'h1);
		m.zz(1'h0);
		check("sleep off", {17'h0, slp}, 18'h0);
		rst(1'h0);
		m.oe(1'h0);
		burst(2'h2, 1'h1);
		report_and_stop();
	end
endmodule // test_pbss_sram
`default_nettype wire
